// file: hw/tsr_regs.sv
// Status and interrupt register bank of the timing source.
//
// Behaviour
// [RULE_01] Input four validity change sets mid bit 0.
// [RULE_02] Mid bits five to one never hold events.
// [RULE_03] Secondary loop lock change sets high bit 6.
// [RULE_04] Lock change flag clears on one; zero ignored.
// [RULE_05] High byte resets to 0x50, others unused.
// [RULE_06] Frequency register shows word bits 18:16.
// [RULE_07] Operating state read-only, reset 0x41, fields.
// [RULE_08] Mid interrupt byte resets to 0x7f.
// [RULE_09] Two missing reference cycles set mid bit 6.
// [RULE_10] Reads have no side effect on flags.
`timescale 1ns/1ps
module tsr_regs
    import tsr_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire tsr_pkg::tsr_bus_req_type   bus_req,
    input  wire tsr_pkg::tsr_status_in_type status_in,
    output logic [7:0]                      rd_data,
    output logic                            rd_valid
);
    import tsr_pkg::*;

    typedef struct packed {
        logic [7:0]            rd_data_r;
        logic                  rd_valid_r;
        logic [FREQ_W-1:0]     freq_r;
        logic                  lock_r;
        logic                  pwarn_r;
        logic                  swarn_r;
        logic [OP_MODE_W-1:0]  mode_r;
        logic                  prev_in4_r;
        logic                  edge_seen_r;
        logic [1:0]            miss_cnt_r;
    } tsr_state_type;

    tsr_state_type st_r;
    tsr_state_type st_nxt;

    logic       in4_set;
    logic       lock_set;
    logic       mode_set;
    logic       refail_set;
    logic       mid_wr;
    logic       high_wr;
    logic       in4_flag;
    logic       lock_flag;
    logic       mode_flag;
    logic       refail_flag;
    logic [7:0] mid_val;
    logic [7:0] high_val;
    logic [7:0] op_val;
    logic [7:0] freq_val;

    assign mid_wr  = bus_req.wr && (bus_req.addr == ADDR_INT_MID);
    assign high_wr = bus_req.wr && (bus_req.addr == ADDR_INT_HIGH);

    // Events are compared against the registered copy of each status.
    assign in4_set  = status_in.input_four_valid != st_r.prev_in4_r; // [RULE_01]
    assign lock_set = status_in.secondary_loop_locked != st_r.lock_r; // [RULE_03]
    assign mode_set = status_in.primary_loop_state != st_r.mode_r;
    // The flag fires once, on the period that completes the second miss.
    assign refail_set = status_in.primary_ref_period && !st_r.edge_seen_r
                        && (st_r.miss_cnt_r == MISS_ONE); // [RULE_09]

    tsr_flag #(.RESET_VAL(RST_INT_MID[BIT_MID_IN4])) u_in4 ( // [RULE_08]
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (in4_set),
        .clr      (mid_wr && bus_req.wdata[BIT_MID_IN4]),
        .flag     (in4_flag)
    );

    tsr_flag #(.RESET_VAL(RST_INT_MID[BIT_MID_REFFL])) u_refail (
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (refail_set),
        .clr      (mid_wr && bus_req.wdata[BIT_MID_REFFL]),
        .flag     (refail_flag)
    );

    tsr_flag #(.RESET_VAL(RST_INT_MID[BIT_MID_MODE])) u_mode (
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (mode_set),
        .clr      (mid_wr && bus_req.wdata[BIT_MID_MODE]),
        .flag     (mode_flag)
    );

    tsr_flag #(.RESET_VAL(RST_INT_HIGH[BIT_HIGH_LOCK])) u_lock ( // [RULE_05]
        .core_clk (core_clk),
        .rst      (rst),
        .set_evt  (lock_set),
        .clr      (high_wr && bus_req.wdata[BIT_HIGH_LOCK]), // [RULE_04]
        .flag     (lock_flag)
    );

    always_comb begin
        mid_val = MID_UNUSED_VAL; // [RULE_02]
        mid_val[BIT_MID_MODE]  = mode_flag;
        mid_val[BIT_MID_REFFL] = refail_flag;
        mid_val[BIT_MID_IN4]   = in4_flag;
        high_val = HIGH_UNUSED_VAL;
        high_val[BIT_HIGH_LOCK] = lock_flag;
        op_val = 8'h00;
        op_val[BIT_OP_LOCK]  = st_r.lock_r; // [RULE_07]
        op_val[BIT_OP_PWARN] = st_r.pwarn_r;
        op_val[BIT_OP_SWARN] = st_r.swarn_r;
        op_val[OP_MODE_LSB +: OP_MODE_W] = st_r.mode_r;
        freq_val = 8'h00;
        freq_val[FREQ_W-1:0] = st_r.freq_r; // [RULE_06]
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.freq_r     = status_in.loop_frequency_word;
        st_nxt.lock_r     = status_in.secondary_loop_locked;
        st_nxt.pwarn_r    = status_in.primary_freq_warning;
        st_nxt.swarn_r    = status_in.secondary_freq_warning;
        st_nxt.mode_r     = status_in.primary_loop_state;
        st_nxt.prev_in4_r = status_in.input_four_valid;
        // Count whole reference periods that pass without an edge.
        if (status_in.primary_ref_period) begin
            st_nxt.edge_seen_r = status_in.primary_ref_edge;
            if (st_r.edge_seen_r) begin
                st_nxt.miss_cnt_r = MISS_ZERO;
            end else if (st_r.miss_cnt_r != MISS_LIMIT) begin
                st_nxt.miss_cnt_r = st_r.miss_cnt_r + MISS_ONE; // [RULE_09]
            end
        end else if (status_in.primary_ref_edge) begin
            st_nxt.edge_seen_r = 1'b1;
        end
        // Reads only sample; they never touch a flag.
        st_nxt.rd_valid_r = bus_req.rd; // [RULE_10]
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_INT_MID: begin
                    st_nxt.rd_data_r = mid_val;
                end
                ADDR_FREQ_TOP: begin
                    st_nxt.rd_data_r = freq_val;
                end
                ADDR_INT_HIGH: begin
                    st_nxt.rd_data_r = high_val;
                end
                ADDR_OP_STATE: begin
                    st_nxt.rd_data_r = op_val;
                end
                default: begin
                    st_nxt.rd_data_r = RD_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.rd_data_r   <= RD_UNMAPPED;
            st_r.rd_valid_r  <= 1'b0;
            st_r.freq_r      <= RST_FREQ_TOP[FREQ_W-1:0];
            st_r.lock_r      <= RST_OP_STATE[BIT_OP_LOCK];
            st_r.pwarn_r     <= RST_OP_STATE[BIT_OP_PWARN];
            st_r.swarn_r     <= RST_OP_STATE[BIT_OP_SWARN];
            st_r.mode_r      <= RST_OP_STATE[OP_MODE_LSB +: OP_MODE_W];
            st_r.prev_in4_r  <= 1'b0;
            st_r.edge_seen_r <= 1'b1;
            st_r.miss_cnt_r  <= MISS_ZERO;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data  = st_r.rd_data_r;
    assign rd_valid = st_r.rd_valid_r;

    sequence lock_moves_s;
        status_in.secondary_loop_locked != st_r.lock_r;
    endsequence

    sequence read_mid_s;
        bus_req.rd && bus_req.addr == ADDR_INT_MID;
    endsequence

    in4_change_set_a: assert property ( // [RULE_01]
        @(posedge core_clk) disable iff (rst)
        in4_set |=> mid_val[BIT_MID_IN4])
        else $error("Input four change did not set its flag.");

    mid_unused_bits_a: assert property ( // [RULE_02]
        @(posedge core_clk) disable iff (rst)
        read_mid_s |=> (rd_data & MID_UNUSED_VAL) == MID_UNUSED_VAL)
        else $error("Unused mid bits changed.");

    lock_change_set_a: assert property ( // [RULE_03]
        @(posedge core_clk) disable iff (rst)
        lock_moves_s |=> lock_flag)
        else $error("Lock change did not set the flag.");

    lock_w1c_clear_a: assert property ( // [RULE_04]
        @(posedge core_clk) disable iff (rst)
        high_wr && bus_req.wdata[BIT_HIGH_LOCK] && !lock_set
        |=> !lock_flag)
        else $error("Write one did not clear lock flag.");

    lock_w0_hold_a: assert property ( // [RULE_04]
        @(posedge core_clk) disable iff (rst)
        lock_flag && !(high_wr && bus_req.wdata[BIT_HIGH_LOCK])
        |=> lock_flag)
        else $error("Lock flag dropped without a clear.");

    high_read_val_a: assert property ( // [RULE_05]
        @(posedge core_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == ADDR_INT_HIGH
        |=> rd_data[BIT_HIGH_LOCK] == $past(lock_flag)
            && rd_data[7] == 1'b0 && rd_data[5:0] == HIGH_UNUSED_VAL[5:0])
        else $error("High byte read value wrong.");

    freq_read_val_a: assert property ( // [RULE_06]
        @(posedge core_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == ADDR_FREQ_TOP ##1 1'b1
        |-> rd_data[7:FREQ_W] == 5'h00
            && rd_data[FREQ_W-1:0] == $past(status_in.loop_frequency_word, 2))
        else $error("Frequency read value wrong.");

    op_state_read_a: assert property ( // [RULE_07]
        @(posedge core_clk) disable iff (rst)
        bus_req.rd && bus_req.addr == ADDR_OP_STATE
        |=> rd_data[BIT_OP_LOCK] == $past(st_r.lock_r)
            && rd_data[7] == 1'b0 && rd_data[3] == 1'b0)
        else $error("Operating state read value wrong.");

    refail_two_miss_a: assert property ( // [RULE_09]
        @(posedge core_clk) disable iff (rst)
        refail_set |-> st_r.miss_cnt_r == MISS_ONE ##1 refail_flag)
        else $error("Reference failure flag not raised.");

    read_no_effect_a: assert property ( // [RULE_10]
        @(posedge core_clk) disable iff (rst)
        read_mid_s and (!bus_req.wr && !in4_set && !mode_set && !refail_set)
        |=> $stable(mid_val))
        else $error("Read changed the mid flags.");
endmodule // tsr_regs

// file: hw/tsr_pkg.sv
// Package with register map, reset values and carrier types for the bank.
package tsr_pkg;
    localparam logic [7:0] ADDR_INT_MID   = 8'h06;
    localparam logic [7:0] ADDR_FREQ_TOP  = 8'h07;
    localparam logic [7:0] ADDR_INT_HIGH  = 8'h08;
    localparam logic [7:0] ADDR_OP_STATE  = 8'h09;

    localparam logic [7:0] RST_INT_MID    = 8'h7f;
    localparam logic [7:0] RST_FREQ_TOP   = 8'h00;
    localparam logic [7:0] RST_INT_HIGH   = 8'h50;
    localparam logic [7:0] RST_OP_STATE   = 8'h41;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;

    // Unused bits read back as their reset pattern and never move.
    localparam logic [7:0] MID_UNUSED_VAL  = 8'h3e;
    localparam logic [7:0] HIGH_UNUSED_VAL = 8'h10;

    localparam int BIT_MID_MODE   = 7;
    localparam int BIT_MID_REFFL  = 6;
    localparam int BIT_MID_IN4    = 0;
    localparam int BIT_HIGH_LOCK  = 6;
    localparam int BIT_OP_LOCK    = 6;
    localparam int BIT_OP_PWARN   = 5;
    localparam int BIT_OP_SWARN   = 4;
    localparam int OP_MODE_LSB    = 0;
    localparam int OP_MODE_W      = 3;
    localparam int FREQ_W         = 3;

    localparam logic [1:0] MISS_LIMIT = 2'h2;
    localparam logic [1:0] MISS_ZERO  = 2'h0;
    localparam logic [1:0] MISS_ONE   = 2'h1;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tsr_bus_req_type;

    typedef struct packed {
        logic                  input_four_valid;
        logic                  secondary_loop_locked;
        logic                  primary_freq_warning;
        logic                  secondary_freq_warning;
        logic [OP_MODE_W-1:0]  primary_loop_state;
        logic [FREQ_W-1:0]     loop_frequency_word;
        logic                  primary_ref_edge;
        logic                  primary_ref_period;
    } tsr_status_in_type;
endpackage

// file: hw/tsr_flag.sv
// Sticky interrupt flag, set by hardware and cleared by writing one.
`timescale 1ns/1ps
module tsr_flag #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic set_evt,
    input  wire logic clr,
    output logic      flag
);
    typedef struct packed {
        logic flag_r;
    } tsr_flag_state_type;

    tsr_flag_state_type st_r;
    tsr_flag_state_type st_nxt;

    // A set in the clear cycle wins, so no event is lost.
    always_comb begin
        st_nxt = st_r;
        if (set_evt) begin
            st_nxt.flag_r = 1'b1;
        end else if (clr) begin
            st_nxt.flag_r = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r.flag_r <= RESET_VAL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flag = st_r.flag_r;
endmodule // tsr_flag

// file: tb/tsr_regs_test.sv
// Self-checking bench for the status and interrupt register bank.
`timescale 1ns/1ps
module tsr_regs_test;
    import tsr_pkg::*;
    logic              core_clk;
    logic              rst;
    tsr_bus_req_type   bus_req;
    tsr_status_in_type status_in;
    tsr_status_in_type s;
    logic [7:0]        rd_data;
    logic              rd_valid;
    int                n_errors;
    int                checks_done;
    int                mid_m;
    int                high_m;
    int                miss_m;
    int                edge_m;
    int                seed;

    tsr_regs tsr_regs_i (
        .core_clk  (core_clk),
        .rst       (rst),
        .bus_req   (bus_req),
        .status_in (status_in),
        .rd_data   (rd_data),
        .rd_valid  (rd_valid)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic complete_run();
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Every drive happens 1 ns after a rising edge, so no race with sampling.
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    function automatic logic [7:0] model_rd(input logic [7:0] a);
        case (a)
            ADDR_INT_MID:  return mid_m[7:0];
            ADDR_FREQ_TOP: return {5'h00, status_in.loop_frequency_word};
            ADDR_INT_HIGH: return high_m[7:0];
            ADDR_OP_STATE: return {1'b0, status_in.secondary_loop_locked,
                                   status_in.primary_freq_warning,
                                   status_in.secondary_freq_warning, 1'b0,
                                   status_in.primary_loop_state};
            default:       return 8'h00;
        endcase
    endfunction

    task automatic rd_chk(input logic [7:0] a);
        int i;
        bus_req.rd   = 1'b1;
        bus_req.addr = a;
        tick();
        bus_req.rd = 1'b0;
        for (i = 0; i < 3 && rd_valid !== 1'b1; i++) tick();
        if (i == 3) begin
            n_errors++;
            $display("CHECK FAILED at %0t: no read answer", $time);
            complete_run();
        end else begin
            compare(8'(i), 8'h00);
            compare(rd_data, model_rd(a));
            // A gap cycle lets the strobe fall back low before the next read; the bench checks it.
            tick();
            compare(8'(rd_valid), 8'h00);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req.wr    = 1'b1;
        bus_req.addr  = a;
        bus_req.wdata = d;
        tick();
        bus_req.wr = 1'b0;
        if (a == ADDR_INT_MID) mid_m &= ~(d & 8'hc1);
        if (a == ADDR_INT_HIGH) high_m &= ~(d & 8'h40);
        tick();
    endtask

    // Registered status needs a couple of edges before a read shows it.
    task automatic set_st(input tsr_status_in_type n);
        if (n.input_four_valid != status_in.input_four_valid) mid_m |= 'h01;
        if (n.secondary_loop_locked != status_in.secondary_loop_locked)
            high_m |= 'h40;
        if (n.primary_loop_state != status_in.primary_loop_state)
            mid_m |= 'h80;
        status_in = n;
        repeat (3) tick();
    endtask

    task automatic pulse(input logic e, input logic p);
        if (p) begin
            if (edge_m != 0) miss_m = 0;
            else if (miss_m < 2) begin
                miss_m++;
                if (miss_m == 2) mid_m |= 'h40;
            end
            edge_m = e;
        end else if (e) edge_m = 1;
        status_in.primary_ref_edge   = e;
        status_in.primary_ref_period = p;
        tick();
        status_in.primary_ref_edge   = 1'b0;
        status_in.primary_ref_period = 1'b0;
        tick();
    endtask

    initial begin
        n_errors    = 0;
        checks_done = 0;
        bus_req     = '0;
        status_in   = '0;
        status_in.secondary_loop_locked = 1'b1;
        status_in.primary_loop_state    = 3'h1;
        mid_m  = 'h7f;
        high_m = 'h50;
        miss_m = 0;
        edge_m = 1;
        rst    = 1'b1;
        seed   = $urandom(32'hcbdd);
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        for (int a = 5; a < 11; a++)
            rd_chk(8'(a));
        wr(ADDR_FREQ_TOP, 8'hff);
        wr(ADDR_OP_STATE, 8'hff);
        wr(8'h0a, 8'hff);
        wr(ADDR_INT_MID, 8'h3e);
        wr(ADDR_INT_HIGH, 8'hbf);
        for (int a = 6; a < 10; a++)
            rd_chk(8'(a));
        wr(ADDR_INT_MID, 8'hff);
        wr(ADDR_INT_HIGH, 8'hff);
        for (int k = 0; k < 24; k++) begin
            s = status_in;
            s.input_four_valid       = 1'($urandom);
            s.secondary_loop_locked  = 1'($urandom);
            s.primary_freq_warning   = 1'($urandom);
            s.secondary_freq_warning = 1'($urandom);
            s.primary_loop_state     = 3'($urandom);
            s.loop_frequency_word    = 3'($urandom);
            set_st(s);
            for (int a = 6; a < 10; a++)
                rd_chk(8'(a));
            rd_chk(ADDR_INT_HIGH);
            wr(ADDR_INT_MID, 8'($urandom));
            wr(ADDR_INT_HIGH, 8'($urandom));
            rd_chk(ADDR_INT_MID);
            rd_chk(ADDR_INT_HIGH);
        end
        wr(ADDR_INT_MID, 8'h40);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        wr(ADDR_INT_MID, 8'h40);
        pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        pulse(1'b1, 1'b1);
        pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        // A second reset in mid-run must bring every register back.
        s = '0;
        s.secondary_loop_locked = 1'b1;
        s.primary_loop_state    = 3'h1;
        rst       = 1'b1;
        status_in = s;
        mid_m  = 'h7f;
        high_m = 'h50;
        miss_m = 0;
        edge_m = 1;
        repeat (4) tick();
        rst = 1'b0;
        for (int a = 6; a < 10; a++)
            rd_chk(8'(a));
        repeat (3) pulse(1'b0, 1'b1);
        rd_chk(ADDR_INT_MID);
        complete_run();
    end
endmodule // tsr_regs_test
